//--- logic/multiplicand_move_accumulate_ops.sv
/*
 * Execution engine for the multiplicand low-half clear, the program counter
 * save, the load-and-add and the load-shift-add moves, with a register port,
 * sticky event status and one interrupt output.
 * Assumes instruction words arrive with the operand address already formed,
 * and a data memory that answers a read one cycle after the read enable.
 */
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "mmaops_cfg.svh"

// Contract
// - Clear-low opcode, object mode 1 only, zeroes multiplicand low half in one cycle.
// - Clear-low keeps the multiplicand upper half and touches no flag.
// - Non-repeatable ops run once after a repeat and zero the repeat counter.
// - Load-and-add loads multiplicand upper half and adds shifted product to accumulator.
// - Load-and-add runs N+1 times; flags from last pass, overflow sticky.
// - Negative flag follows accumulator bit 31 after accumulating moves.
// - Zero flag set when whole accumulator is zero after accumulating moves.
// - Overflow flag set on overflow, otherwise left unchanged.
// - Without saturation, overflow counter counts up or down on overflow.
// - With saturation, overflowing result clamps to most positive or negative.
// - Product shift: positive is left shift zero fill, negative arithmetic right.
// - Load-shift-add, mode 1 only, loads upper half, stores it next up, accumulates.
// - Load-shift-add with a register addressing mode raises an illegal trap.
module multiplicand_move_accumulate_ops (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic [21:0] pc_value,
  input  wire logic [15:0] operand_addr,
  output logic             instr_ready,
  output logic             mem_rd_en,
  output logic      [15:0] mem_rd_addr,
  input  wire logic [15:0] mem_rd_data,
  output logic             mem_wr_en,
  output logic      [15:0] mem_wr_addr,
  output logic      [15:0] mem_wr_data,
  output logic             trap_pulse,
  output logic             irq
);

  // ************************************************************
  // State
  // ************************************************************
  mmaops_pkg::state_t state_reg, state_next;
  logic [4:0]  ctrl_reg, ctrl_next;
  logic [15:0] repeat_counter_reg, repeat_counter_next;
  logic [31:0] product_reg, product_next;
  logic [31:0] acc_reg, acc_next;
  logic [31:0] multiplicand_register_reg, multiplicand_register_next;
  logic [3:0]  flags_reg, flags_next;
  logic [5:0]  ovc_reg, ovc_next;
  logic [2:0]  status_reg, status_next;
  logic [2:0]  mask_reg, mask_next;
  logic [31:0] aux_pointer_register_reg [8];
  logic [31:0] aux_pointer_register_next [8];
  logic        is_shift_add_reg, is_shift_add_next;
  logic [15:0] op_addr_reg, op_addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        ready_reg, ready_next;
  logic        rd_en_reg, rd_en_next;
  logic        wr_en_reg, wr_en_next;
  logic [15:0] wr_addr_reg, wr_addr_next;
  logic [15:0] wr_data_reg, wr_data_next;
  logic        trap_reg, trap_next;
  logic        irq_reg, irq_next;

  logic [31:0] shifted_product;
  logic [31:0] add_result;
  logic        add_carry;
  logic        add_ovf_pos;
  logic        add_ovf_neg;
  logic [31:0] acc_operand;
  logic [2:0]  events;

  // ************************************************************
  // Decode helpers
  // ************************************************************
  // Operand field naming a register rather than a memory location
  function automatic logic reg_addressing(input logic [7:0] loc);
    reg_addressing = (loc[7:5] == `LOC_REG_MODE_HI);
  endfunction

  // True when the port address equals the given register byte offset
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ************************************************************
  // Arithmetic path
  // ************************************************************
  product_shifter u_shifter (
    .product     (product_reg),
    .shift_field (ctrl_reg[`CTRL_PM_LSB +: 3]),
    .shifted     (shifted_product)
  );

  // Accumulator input is the accumulator register; software writes reach it a cycle later
  assign acc_operand = acc_reg;

  acc_adder u_adder (
    .acc      (acc_operand),
    .addend   (shifted_product),
    .saturate (ctrl_reg[`CTRL_SAT_BIT]),
    .result   (add_result),
    .carry    (add_carry),
    .ovf_pos  (add_ovf_pos),
    .ovf_neg  (add_ovf_neg)
  );

  // ************************************************************
  // Next-state logic: sequencer, core registers, register port
  // ************************************************************
  always_comb begin
    state_next                 = state_reg;
    ctrl_next                  = ctrl_reg;
    repeat_counter_next        = repeat_counter_reg;
    product_next               = product_reg;
    acc_next                   = acc_reg;
    multiplicand_register_next = multiplicand_register_reg;
    flags_next                 = flags_reg;
    ovc_next                   = ovc_reg;
    mask_next                  = mask_reg;
    is_shift_add_next          = is_shift_add_reg;
    op_addr_next               = op_addr_reg;
    rd_en_next                 = 1'b0;
    wr_en_next                 = 1'b0;
    wr_addr_next               = wr_addr_reg;
    wr_data_next               = wr_data_reg;
    trap_next                  = 1'b0;
    events                     = 3'h0;
    for (int i = 0; i < 8; i++) begin
      aux_pointer_register_next[i] = aux_pointer_register_reg[i];
    end

    // Software writes first so the engine below overrides on a clash
    if (reg_wr) begin
      if (hit(reg_addr, `OFS_CTRL)) ctrl_next = reg_wdata[4:0];
      if (hit(reg_addr, `OFS_REPEAT)) repeat_counter_next = reg_wdata[15:0];
      if (hit(reg_addr, `OFS_PRODUCT)) product_next = reg_wdata;
      if (hit(reg_addr, `OFS_ACC)) acc_next = reg_wdata;
      if (hit(reg_addr, `OFS_MULTIPLICAND)) multiplicand_register_next = reg_wdata;
      if (hit(reg_addr, `OFS_FLAGS)) begin
        flags_next = reg_wdata[3:0];
        ovc_next   = reg_wdata[`FLAG_OVC_LSB +: 6];
      end
      if (hit(reg_addr, `OFS_IRQ_MASK)) mask_next = reg_wdata[2:0];
    end

    case (state_reg)
      mmaops_pkg::ST_IDLE: begin
        if (instr_valid) begin
          if (instr_word == `OP_CLEAR_LOW) begin
            if (ctrl_reg[`CTRL_OBJECT_MODE_BIT_BIT]) begin
              // Upper half and flags untouched
              multiplicand_register_next = {multiplicand_register_reg[31:16],
                                            `LOW_HALF_ZERO};
              events[`EVT_DONE_BIT] = 1'b1;
            end else begin
              trap_next = 1'b1;
              events[`EVT_TRAP_BIT] = 1'b1;
            end
            repeat_counter_next = 16'h0000;
          end else if (instr_word[15:3] == `OP_SAVE_PC_HI) begin
            if (ctrl_reg[`CTRL_OBJECT_MODE_BIT_BIT]) begin
              aux_pointer_register_next[instr_word[2:0]] =
                {10'h000, pc_value};
              events[`EVT_DONE_BIT] = 1'b1;
            end else begin
              trap_next = 1'b1;
              events[`EVT_TRAP_BIT] = 1'b1;
            end
            repeat_counter_next = 16'h0000;
          end else if (instr_word[15:8] == `OP_LOAD_ADD_HI) begin
            // Repeat counter kept: it sets the pass count
            is_shift_add_next = 1'b0;
            op_addr_next      = operand_addr;
            rd_en_next        = 1'b1;
            state_next        = mmaops_pkg::ST_READ;
          end else if (instr_word[15:8] == `OP_SHIFT_ADD_HI) begin
            repeat_counter_next = 16'h0000;
            if (!ctrl_reg[`CTRL_OBJECT_MODE_BIT_BIT] || reg_addressing(instr_word[7:0])) begin
              trap_next = 1'b1;
              events[`EVT_TRAP_BIT] = 1'b1;
            end else begin
              is_shift_add_next = 1'b1;
              op_addr_next      = operand_addr;
              rd_en_next        = 1'b1;
              state_next        = mmaops_pkg::ST_READ;
            end
          end
        end
      end
      mmaops_pkg::ST_READ: begin
        // Read enable is out this cycle; data comes next cycle
        state_next = mmaops_pkg::ST_EXEC;
      end
      mmaops_pkg::ST_EXEC: begin
        multiplicand_register_next = {mem_rd_data,
                                      multiplicand_register_reg[15:0]};
        acc_next                   = add_result;
        flags_next[`FLAG_N_BIT]    = add_result[31];
        flags_next[`FLAG_Z_BIT]    = (add_result == 32'h00000000);
        flags_next[`FLAG_C_BIT]    = add_carry;
        // Only ever set, so an early pass overflow survives the repeat
        if (add_ovf_pos || add_ovf_neg) begin
          flags_next[`FLAG_V_BIT] = 1'b1;
          events[`EVT_OVF_BIT]    = 1'b1;
        end
        if (!ctrl_reg[`CTRL_SAT_BIT] && add_ovf_pos) begin
          ovc_next = ovc_reg + 6'h01;
        end else if (!ctrl_reg[`CTRL_SAT_BIT] && add_ovf_neg) begin
          ovc_next = ovc_reg - 6'h01;
        end
        if (is_shift_add_reg) begin
          // Write issued only after the read data is in hand
          wr_en_next   = 1'b1;
          wr_addr_next = op_addr_reg + 16'h0001;
          wr_data_next = mem_rd_data;
          state_next   = mmaops_pkg::ST_WRITE;
        end else if (repeat_counter_reg != 16'h0000) begin
          repeat_counter_next = repeat_counter_reg - 16'h0001;
          rd_en_next          = 1'b1;
          state_next          = mmaops_pkg::ST_READ;
        end else begin
          events[`EVT_DONE_BIT] = 1'b1;
          state_next            = mmaops_pkg::ST_IDLE;
        end
      end
      mmaops_pkg::ST_WRITE: begin
        events[`EVT_DONE_BIT] = 1'b1;
        state_next            = mmaops_pkg::ST_IDLE;
      end
      default: begin
        state_next = mmaops_pkg::ST_IDLE;
      end
    endcase

    // Ready only while the next cycle is idle
    ready_next = (state_next == mmaops_pkg::ST_IDLE);

    // Sticky events; a read of status clears, but a new event wins
    status_next = status_reg;
    if (reg_rd && hit(reg_addr, `OFS_IRQ_STATUS)) begin
      status_next = 3'h0;
    end
    status_next = status_next | events;
    irq_next    = |(status_next & mask_next);
  end

  // ************************************************************
  // Read data, one cycle after the read strobe; unmapped reads zero
  // ************************************************************
  always_comb begin
    rdata_next = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        `OFS_CTRL:         rdata_next = {27'h0000000, ctrl_reg};
        `OFS_REPEAT:       rdata_next = {16'h0000, repeat_counter_reg};
        `OFS_PRODUCT:      rdata_next = product_reg;
        `OFS_ACC:          rdata_next = acc_reg;
        `OFS_MULTIPLICAND: rdata_next = multiplicand_register_reg;
        `OFS_FLAGS:        rdata_next = {18'h00000, ovc_reg, 4'h0, flags_reg};
        `OFS_IRQ_STATUS:   rdata_next = {29'h00000000, status_reg};
        `OFS_IRQ_MASK:     rdata_next = {29'h00000000, mask_reg};
        default: begin
          if (reg_addr >= `OFS_AUX_BASE && reg_addr <= `OFS_AUX_TOP &&
              reg_addr[1:0] == 2'h0) begin
            rdata_next = aux_pointer_register_reg[reg_addr[4:2]];
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg                 <= mmaops_pkg::ST_IDLE;
      ctrl_reg                  <= `CTRL_RESET;
      repeat_counter_reg        <= 16'h0000;
      product_reg               <= 32'h00000000;
      acc_reg                   <= 32'h00000000;
      multiplicand_register_reg <= 32'h00000000;
      flags_reg                 <= 4'h0;
      ovc_reg                   <= 6'h00;
      status_reg                <= 3'h0;
      mask_reg                  <= `MASK_RESET;
      is_shift_add_reg          <= 1'b0;
      op_addr_reg               <= 16'h0000;
      rdata_reg                 <= 32'h00000000;
      ready_reg                 <= 1'b1;
      rd_en_reg                 <= 1'b0;
      wr_en_reg                 <= 1'b0;
      wr_addr_reg               <= 16'h0000;
      wr_data_reg               <= 16'h0000;
      trap_reg                  <= 1'b0;
      irq_reg                   <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        aux_pointer_register_reg[i] <= 32'h00000000;
      end
    end else begin
      state_reg                 <= state_next;
      ctrl_reg                  <= ctrl_next;
      repeat_counter_reg        <= repeat_counter_next;
      product_reg               <= product_next;
      acc_reg                   <= acc_next;
      multiplicand_register_reg <= multiplicand_register_next;
      flags_reg                 <= flags_next;
      ovc_reg                   <= ovc_next;
      status_reg                <= status_next;
      mask_reg                  <= mask_next;
      is_shift_add_reg          <= is_shift_add_next;
      op_addr_reg               <= op_addr_next;
      rdata_reg                 <= rdata_next;
      ready_reg                 <= ready_next;
      rd_en_reg                 <= rd_en_next;
      wr_en_reg                 <= wr_en_next;
      wr_addr_reg               <= wr_addr_next;
      wr_data_reg               <= wr_data_next;
      trap_reg                  <= trap_next;
      irq_reg                   <= irq_next;
      for (int i = 0; i < 8; i++) begin
        aux_pointer_register_reg[i] <= aux_pointer_register_next[i];
      end
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata   = rdata_reg;
  assign instr_ready = ready_reg;
  assign mem_rd_en   = rd_en_reg;
  assign mem_rd_addr = op_addr_reg;
  assign mem_wr_en   = wr_en_reg;
  assign mem_wr_addr = wr_addr_reg;
  assign mem_wr_data = wr_data_reg;
  assign trap_pulse  = trap_reg;
  assign irq         = irq_reg;

endmodule // multiplicand_move_accumulate_ops

//--- logic/mmaops_cfg.svh
/*
 * Constants of the multiplicand move and accumulate block: register offsets,
 * field positions, reset values and opcode patterns.
 * Assumes inclusion by bare name from the top module and the accumulator adder.
 */
`ifndef MMAOPS_CFG_SVH
`define MMAOPS_CFG_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define OFS_CTRL        8'h00
`define OFS_REPEAT      8'h04
`define OFS_PRODUCT     8'h08
`define OFS_ACC         8'h0C
`define OFS_MULTIPLICAND 8'h10
`define OFS_FLAGS       8'h14
`define OFS_IRQ_STATUS  8'h18
`define OFS_IRQ_MASK    8'h1C
`define OFS_AUX_BASE    8'h20
`define OFS_AUX_TOP     8'h3C

// ************************************************************
// Field positions
// ************************************************************
`define CTRL_OBJECT_MODE_BIT_BIT 0
`define CTRL_SAT_BIT     1
`define CTRL_PM_LSB      2
`define FLAG_N_BIT       0
`define FLAG_Z_BIT       1
`define FLAG_C_BIT       2
`define FLAG_V_BIT       3
`define FLAG_OVC_LSB     8
`define EVT_TRAP_BIT     0
`define EVT_OVF_BIT      1
`define EVT_DONE_BIT     2

// ************************************************************
// Reset values
// ************************************************************
`define CTRL_RESET       5'h06
`define MASK_RESET       3'h0

// ************************************************************
// Opcode patterns
// ************************************************************
`define OP_CLEAR_LOW     16'h5656
`define OP_SAVE_PC_HI    13'h07CB
`define OP_LOAD_ADD_HI   8'h10
`define OP_SHIFT_ADD_HI  8'hA7
`define LOC_REG_MODE_HI  3'h5
`define LOW_HALF_ZERO    16'h0000
`define SAT_POS          32'h7FFFFFFF
`define SAT_NEG          32'h80000000

`endif

//--- logic/mmaops_pkg.sv
/*
 * Types shared by the multiplicand move and accumulate block.
 * Assumes nothing of its surroundings.
 */
package mmaops_pkg;

  // Sequencer states of the operation engine
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_EXEC,
    ST_WRITE
  } state_t;

endpackage

//--- logic/product_shifter.sv
/*
 * Product shifter: scales the product register by the product shift field.
 * Assumes a purely combinational use inside the accumulate path.
 */
`timescale 1ns/1ps

module product_shifter (
  input  wire logic [31:0] product,
  input  wire logic [2:0]  shift_field,
  output logic      [31:0] shifted
);

  // Code 0 shifts left by one, 1 passes, 2..7 shift right by 1..6
  always_comb begin
    case (shift_field)
      3'h0:    shifted = {product[30:0], 1'b0};
      3'h1:    shifted = product;
      default: shifted = $signed(product) >>> (shift_field - 3'h1);
    endcase
  end

endmodule // product_shifter

//--- logic/acc_adder.sv
/*
 * Accumulator adder with carry, signed overflow detection and optional
 * saturation. Assumes a purely combinational use.
 */
`timescale 1ns/1ps
`include "mmaops_cfg.svh"

module acc_adder (
  input  wire logic [31:0] acc,
  input  wire logic [31:0] addend,
  input  wire logic        saturate,
  output logic      [31:0] result,
  output logic             carry,
  output logic             ovf_pos,
  output logic             ovf_neg
);

  logic [32:0] sum;

  // Overflow when like signs give an opposite sign
  always_comb begin
    sum     = {1'b0, acc} + {1'b0, addend};
    carry   = sum[32];
    ovf_pos = ~acc[31] & ~addend[31] & sum[31];
    ovf_neg = acc[31] & addend[31] & ~sum[31];
    if (saturate && ovf_pos) begin
      result = `SAT_POS;
    end else if (saturate && ovf_neg) begin
      result = `SAT_NEG;
    end else begin
      result = sum[31:0];
    end
  end

endmodule // acc_adder

//--- verification/mmaops_checker.sv
/* Port checker for the multiplicand move engine, bound to its top module.
   Assumes one clock and the active-low asynchronous reset rst_n. */
`timescale 1ns/1ps
module mmaops_checker (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] operand_addr,
  input wire logic        instr_ready,
  input wire logic        mem_rd_en,
  input wire logic [15:0] mem_rd_addr,
  input wire logic [15:0] mem_rd_data,
  input wire logic        mem_wr_en,
  input wire logic [15:0] mem_wr_addr,
  input wire logic [15:0] mem_wr_data,
  input wire logic        trap_pulse
);
  // ********************
  // Timing relations
  // ********************
  logic take;
  logic regm;
  // Accepted instruction, and a store-form op naming a register operand
  assign take = instr_valid && instr_ready;
  assign regm = instr_word[15:8] == 8'hA7 && instr_word[7:5] == 3'h5;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_CLR_ONE: assert property (
    take && instr_word == 16'h5656 |=> instr_ready && !mem_rd_en)
    else $error("clear-low took more than one cycle");
  AST_PC_ONE: assert property (
    take && instr_word[15:3] == 13'h07CB |=> instr_ready && !mem_rd_en)
    else $error("pc save took more than one cycle");
  AST_LOAD_RD: assert property (
    take && instr_word[15:8] == 8'h10 |=> mem_rd_en && mem_rd_addr == $past(operand_addr))
    else $error("load-and-add read missing or misaddressed");
  AST_LOAD_NOWR: assert property (
    take && instr_word[15:8] == 8'h10 |=> !mem_wr_en [*3])
    else $error("load-and-add wrote memory");
  AST_WR_AFTER_RD: assert property (
    mem_wr_en |-> $past(mem_rd_en, 2))
    else $error("write not preceded by operand read");
  AST_WR_ADDR: assert property (
    mem_wr_en |-> mem_wr_addr == mem_rd_addr + 16'h0001)
    else $error("store address is not the next location");
  AST_WR_DATA: assert property (
    mem_wr_en |-> mem_wr_data == $past(mem_rd_data))
    else $error("stored word differs from loaded word");
  AST_REG_TRAP: assert property (
    take && regm |-> ##[1:2] trap_pulse)
    else $error("register operand did not trap");
  AST_REG_NOMEM: assert property (
    take && regm |=> (!mem_rd_en && !mem_wr_en) [*3])
    else $error("trapped op touched memory");
  AST_TRAP_ONE: assert property (
    $rose(trap_pulse) |=> !trap_pulse)
    else $error("trap pulse longer than one cycle");
endmodule // mmaops_checker

bind multiplicand_move_accumulate_ops mmaops_checker u_mmaops_checker (
  .sys_clk, .rst_n, .instr_valid, .instr_word, .operand_addr, .instr_ready,
  .mem_rd_en, .mem_rd_addr, .mem_rd_data, .mem_wr_en, .mem_wr_addr,
  .mem_wr_data, .trap_pulse
);

//--- verification/data_mem_model.sv
/* Data memory model at the far side of the move engine.
   Assumes the engine clock and only 256 words in use. */
`timescale 1ns/1ps
module data_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        mem_rd_en,
  input  wire logic [15:0] mem_rd_addr,
  output logic      [15:0] mem_rd_data,
  input  wire logic        mem_wr_en,
  input  wire logic [15:0] mem_wr_addr,
  input  wire logic [15:0] mem_wr_data
);
  // ********************
  // Storage
  // ********************
  logic [15:0] mem [0:255];
  initial mem_rd_data = 16'h0000;
  // Answer one cycle late; idle bus toggles so stale data never looks valid
  always @(posedge sys_clk) begin
    if (mem_wr_en) begin
      mem[mem_wr_addr[7:0]] <= mem_wr_data;
    end
    mem_rd_data <= mem_rd_en ? mem[mem_rd_addr[7:0]] : ~mem_rd_data;
  end
endmodule // data_mem_model

//--- verification/tb_multiplicand_move_accumulate_ops.sv
/* Self-checking bench for the multiplicand move engine.
   Assumes the memory model and the bound checker are compiled first. */
`timescale 1ns/1ps
module tb_multiplicand_move_accumulate_ops;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0;
  logic [21:0] pc_value = 22'h0;
  logic [15:0] operand_addr = 16'h0;
  logic        instr_ready, mem_rd_en, mem_wr_en, trap_pulse, irq;
  logic [15:0] mem_rd_addr, mem_rd_data, mem_wr_addr, mem_wr_data;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;

  multiplicand_move_accumulate_ops u_multiplicand_move_accumulate_ops (
    .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .instr_valid, .instr_word, .pc_value, .operand_addr, .instr_ready,
    .mem_rd_en, .mem_rd_addr, .mem_rd_data, .mem_wr_en, .mem_wr_addr,
    .mem_wr_data, .trap_pulse, .irq);
  data_mem_model u_mem (.sys_clk, .mem_rd_en, .mem_rd_addr, .mem_rd_data,
    .mem_wr_en, .mem_wr_addr, .mem_wr_data);

  // ********************
  // Clock, timeout, verdict
  // ********************
  always #12.5 sys_clk = ~sys_clk;
  // Whole run needs well under this many cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ********************
  // Bus and compare tasks; each bus task is entered and left on a rising edge, chk takes no time
  // ********************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFFFFFF);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata & m);
    @(posedge sys_clk);
  endtask
  task automatic irq_is(input string nm, input logic e);
    #1;
    chk(nm, {31'h0, e}, {31'h0, irq});
    @(posedge sys_clk);
  endtask
  task automatic issue(input logic [15:0] w, input logic [15:0] a, input logic [21:0] p = 22'h0);
    int n = 0;
    instr_word <= w;
    operand_addr <= a;
    pc_value <= p;
    instr_valid <= 1'b1;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    while (instr_ready !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("ready", 32'h1, {31'h0, instr_ready});
    @(posedge sys_clk);
  endtask
  task automatic prep(input logic [31:0] c, input logic [31:0] p, input logic [31:0] a);
    wr(8'h00, c);
    wr(8'h08, p);
    wr(8'h0C, a);
    wr(8'h14, 32'h0);
  endtask

  // ********************
  // Scenarios
  // ********************
  initial begin
    logic [31:0] e;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rchk("ctrl_rst", 8'h00, 32'h00000006);
    rchk("mask_rst", 8'h1C, 32'h0);
    rchk("unmapped", 8'h44, 32'h0);
    wr(8'h20, 32'hFFFFFFFF);
    rchk("aux_ro", 8'h20, 32'h0);
    // Clear-low refused in mode 0, then done in mode 1
    wr(8'h10, 32'h12345678);
    wr(8'h14, 32'h00000105);
    issue(16'h5656, 16'h0);
    rchk("xt_mode0", 8'h10, 32'h12345678);
    irq_is("irq_masked", 1'b0);
    rchk("trap_st", 8'h18, 32'h1, 32'h1);
    wr(8'h00, 32'h7);
    issue(16'h5656, 16'h0);
    rchk("xt_clr", 8'h10, 32'h12340000);
    rchk("flags_clr", 8'h14, 32'h00000105);
    // Program counter into every aux register
    for (int i = 0; i < 8; i++) begin
      issue(16'h3E58 | 16'(i), 16'h0, 22'h2AAAA0 + 22'(i));
      rchk("aux", 8'h20 + 8'(4 * i), {10'h0, 22'h2AAAA0 + 22'(i)});
    end
    rchk("flags_pc", 8'h14, 32'h00000105);
    // Accumulate: overflow count, saturation, carry and zero
    u_mem.mem[8'h20] = 16'hBEEF;
    prep(32'h5, 32'h10, 32'h7FFFFFF8);
    issue(16'h1020, 16'h0020);
    rchk("acc_ovf", 8'h0C, 32'h80000008);
    rchk("xt_hi", 8'h10, 32'hBEEF0000, 32'hFFFF0000);
    rchk("flags_ovf", 8'h14, 32'h00000109);
    prep(32'h7, 32'h10, 32'h7FFFFFF8);
    issue(16'h1020, 16'h0020);
    rchk("acc_sat", 8'h0C, 32'h7FFFFFFF);
    rchk("flags_sat", 8'h14, 32'h00000008);
    prep(32'h5, 32'h10, 32'hFFFFFFF0);
    wr(8'h14, 32'h8);
    issue(16'h1020, 16'h0020);
    rchk("acc_zero", 8'h0C, 32'h0);
    rchk("flags_zc", 8'h14, 32'h0000000E);
    // Negative overflow: counter steps down, or clamps when saturating
    prep(32'h5, 32'h80000000, 32'h80000000);
    issue(16'h1020, 16'h0020);
    rchk("flags_neg", 8'h14, 32'h00003F0E);
    prep(32'h7, 32'h80000000, 32'h80000000);
    issue(16'h1020, 16'h0020);
    rchk("acc_satn", 8'h0C, 32'h80000000);
    // Every product shift setting
    for (int k = 0; k < 8; k++) begin
      prep({27'h0, 3'(k), 2'h1}, 32'h80000010, 32'h0);
      issue(16'h1020, 16'h0020);
      e = (k == 0) ? 32'h00000020 : $unsigned($signed(32'h80000010) >>> (k - 1));
      rchk("acc_pm", 8'h0C, e);
    end
    // Repeat with a middle-pass overflow, then a non-repeatable op
    prep(32'h5, 32'h1, 32'h7FFFFFFE);
    wr(8'h04, 32'h2);
    issue(16'h1020, 16'h0020);
    rchk("acc_rep", 8'h0C, 32'h80000001);
    rchk("flags_rep", 8'h14, 32'h9, 32'hF);
    rchk("rpt_done", 8'h04, 32'h0);
    wr(8'h04, 32'h3);
    issue(16'h5656, 16'h0);
    rchk("rpt_clr", 8'h04, 32'h0);
    // Load-shift-add store, then a register operand trap with irq
    u_mem.mem[8'h30] = 16'hA55A;
    prep(32'h5, 32'h5, 32'h0);
    issue(16'hA730, 16'h0030);
    chk("mem_next", 32'h0000A55A, {16'h0, u_mem.mem[8'h31]});
    rchk("acc_sh", 8'h0C, 32'h5);
    rchk("xt_sh", 8'h10, 32'hA55A0000, 32'hFFFF0000);
    wr(8'h1C, 32'h1);
    issue(16'hA7A3, 16'h00A3);
    irq_is("irq_on", 1'b1);
    rchk("acc_trap", 8'h0C, 32'h5);
    rchk("st_trap", 8'h18, 32'h1, 32'h1);
    irq_is("irq_off", 1'b0);
    wr(8'h00, 32'h4);
    issue(16'hA730, 16'h0030);
    rchk("st_mode0", 8'h18, 32'h1, 32'h1);
    close_out();
  end
endmodule // tb_multiplicand_move_accumulate_ops
